// *** test/fsr_host.sv ***
module fsr_host (
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdin_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'h0;
    sync_n_o = 1'h1;
    sdin_o = 1'h0;
  end

  // one 24-bit frame, 200 ns bit period, clock idles low
  task automatic frame(input logic [23:0] word, output logic [15:0] rdata,
                       output logic oe_seen);
    rdata = '0;
    oe_seen = 1'h1;
    // keep the select edge away from the core clock edge
    #5;
    sync_n_o = 1'h0;
    #100;
    for (int i = 23; i >= 0; i--) begin
      sdin_o = word[i];
      sclk_o = 1'h1;
      #100;
      sclk_o = 1'h0;
      #50;
      // status arrives in the last 16 bit slots
      if (i < 16) begin
        // an undriven line reads as the inverse of the last level
        rdata[i] = sdo_oe_i ? sdo_i : ~sdo_i;
      end
      oe_seen = oe_seen & sdo_oe_i;
      #50;
    end
    sync_n_o = 1'h1;
    // released data line must not keep its last level
    sdin_o = ~sdin_o;
    #400;
  endtask
endmodule // fsr_host

// *** test/tb_fsr_status.sv ***
module tb_fsr_status;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic swe = 1'h0;
  logic tw = 1'h0;
  logic tv = 1'h0;
  logic pcf = 1'h0;
  logic sclk, sync_n, sdin, serial_data_out, sdo_oe, fault_n, fault_oe, oe;
  logic [15:0] rd;
  fsr_pkg::fsr_flags_s flags = '0;
  fsr_pkg::fsr_status_s st, exp;
  int mismatches = 0;
  int total_checks = 0;

  always #12.5 core_clk = ~core_clk;

  fsr_status u_fsr_status (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .serial_clk_i(sclk), .serial_sync_n_i(sync_n), .serial_data_in_i(sdin),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
    .status_on_write_enable_i(swe), .toggle_write_i(tw),
    .toggle_value_i(tv), .packet_check_fail_i(pcf), .flags_i(flags),
    .fault_status_o(st), .fault_n_o(fault_n), .fault_oe_o(fault_oe));

  fsr_host u_fsr_host (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin),
    .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_bit(input logic got, input logic want);
    chk_word({15'h0, got}, {15'h0, want});
  endtask

  task automatic test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(20);
    arst_n <= 1'h1;
    cyc(4);
    exp = '0;
    chk_word(st, exp);
    chk_bit(fault_oe, 1'h0);
    flags <= '{boost: 4'h1, iout: 4'h4, overtemp: 1'h1, ramp: 1'h1};
    cyc(4);
    exp.boost_compliance = 4'h1;
    exp.ramp_active = 1'h1;
    exp.overtemp = 1'h1;
    exp.current_out = 4'h5;
    chk_word(st, exp);
    chk_bit(fault_oe, 1'h1);
    tw <= 1'h1;
    tv <= 1'h1;
    cyc(1);
    tw <= 1'h0;
    cyc(4);
    exp.user_toggle = 1'h1;
    chk_word(st, exp);
    pcf <= 1'h1;
    cyc(1);
    pcf <= 1'h0;
    flags <= '0;
    cyc(4);
    exp = '0;
    exp.user_toggle = 1'h1;
    exp.packet_check = 1'h1;
    chk_word(st, exp);
    chk_bit(fault_oe, 1'h1);
    chk_bit(fault_n, 1'h0);
    u_fsr_host.frame(24'h180000, rd, oe);
    chk_word(st, exp);
    chk_bit(oe, 1'h0);
    cyc(1);
    swe <= 1'h1;
    cyc(2);
    u_fsr_host.frame(24'h1ce000, rd, oe);
    chk_word(rd, exp);
    chk_bit(oe, 1'h1);
    exp.packet_check = 1'h0;
    chk_word(st, exp);
    chk_bit(fault_oe, 1'h0);
    cyc(1);
    swe <= 1'h0;
    flags <= '{boost: 4'h8, iout: 4'h0, overtemp: 1'h1, ramp: 1'h0};
    cyc(4);
    exp.boost_compliance = 4'h8;
    exp.current_out = 4'h8;
    exp.overtemp = 1'h1;
    u_fsr_host.frame(24'h980000, rd, oe);
    chk_bit(oe, 1'h0);
    u_fsr_host.frame(24'h1ce000, rd, oe);
    chk_word(rd, exp);
    chk_bit(oe, 1'h1);
    test_done();
  end
endmodule // tb_fsr_status

// *** verilog/fsr_map.svh ***
// Notes on behaviour
// - sixteen-bit status word, host reads only
// - status-on-write: status shifted out every frame
// - otherwise status returned by readback sequence
// - boost compliance flag also sets current fault
// - toggle bit follows software register writes only
// - flag last packet check failure
// - ramp bit high while any channel slews
// - overtemperature flag from detector input
// - per-channel output current fault bits
// - status read clears packet error, releases fault unless a current or temperature flag is set
// - status-on-write disabled after reset
// - fault output on current, packet, temperature flags
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_FRAME_BITS 5'd24
`define FSR_RW_BIT 23
`define FSR_RD_MSB 20
`define FSR_RD_LSB 16
`define FSR_RD_STATUS 5'h18
`define FSR_PAD_BITS 8'h00
`define FSR_UNUSED_BITS 4'h0
`define FSR_RST_TOGGLE 1'b0
`define FSR_RST_PEC 1'b0
`define FSR_RST_SWE 1'b0
`endif

// *** verilog/fsr_pkg.sv ***
package fsr_pkg;
  typedef struct packed {
    logic [3:0] boost;
    logic [3:0] iout;
    logic overtemp;
    logic ramp;
  } fsr_flags_s;

  typedef struct packed {
    logic [3:0] boost_compliance;
    logic user_toggle;
    logic packet_check;
    logic ramp_active;
    logic overtemp;
    logic [3:0] unused;
    logic [3:0] current_out;
  } fsr_status_s;

  typedef struct packed {
    logic [1:0] sclk_q;
    logic [1:0] sync_q;
    logic [1:0] sdin_q;
    fsr_flags_s flags_q1;
    fsr_flags_s flags_q2;
    logic sclk_prev;
    logic sync_prev;
    logic [23:0] shift_out;
    logic [23:0] shift_in;
    logic [4:0] bit_cnt;
    logic answering;
    logic rd_pending;
    logic pec_err;
    logic user_toggle;
    logic status_on_write_enable;
  } fsr_state_s;
endpackage

// *** verilog/fsr_status.sv ***
`include "fsr_map.svh"

module fsr_status (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_sync_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  input wire logic status_on_write_enable_i,
  input wire logic toggle_write_i,
  input wire logic toggle_value_i,
  input wire logic packet_check_fail_i,
  input wire fsr_pkg::fsr_flags_s flags_i,
  output fsr_pkg::fsr_status_s fault_status_o,
  output logic fault_n_o,
  output logic fault_oe_o
);
  logic [1:0] rst_q;
  logic rst_n;
  fsr_pkg::fsr_state_s r;
  fsr_pkg::fsr_state_s next_r;
  fsr_pkg::fsr_status_s status;
  logic sclk_s;
  logic sync_n_s;
  logic rise;
  logic fall;
  logic frame_start;
  logic frame_end;
  logic status_read_done;
  logic rd_status_cmd;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  assign sclk_s = r.sclk_q[1];
  assign sync_n_s = r.sync_q[1];
  assign rise = sclk_s & ~r.sclk_prev;
  assign fall = ~sclk_s & r.sclk_prev;
  assign frame_start = r.sync_prev & ~sync_n_s;
  assign frame_end = ~r.sync_prev & sync_n_s;
  assign status_read_done = frame_end & r.answering;
  assign rd_status_cmd = (r.bit_cnt == `FSR_FRAME_BITS) &
    r.shift_in[`FSR_RW_BIT] &
    (r.shift_in[`FSR_RD_MSB:`FSR_RD_LSB] == `FSR_RD_STATUS);

  // live word; no write path reaches it
  always_comb begin
    status.boost_compliance = r.flags_q2.boost;
    status.user_toggle = r.user_toggle;
    status.packet_check = r.pec_err;
    status.ramp_active = r.flags_q2.ramp;
    status.overtemp = r.flags_q2.overtemp;
    status.unused = `FSR_UNUSED_BITS;
    status.current_out = r.flags_q2.iout | r.flags_q2.boost;
  end

  always_comb begin
    next_r = r;
    next_r.sclk_q = {r.sclk_q[0], serial_clk_i};
    next_r.sync_q = {r.sync_q[0], serial_sync_n_i};
    next_r.sdin_q = {r.sdin_q[0], serial_data_in_i};
    next_r.flags_q1 = flags_i;
    next_r.flags_q2 = r.flags_q1;
    next_r.sclk_prev = sclk_s;
    next_r.sync_prev = sync_n_s;
    next_r.status_on_write_enable = status_on_write_enable_i;
    if (toggle_write_i) begin
      next_r.user_toggle = toggle_value_i;
    end
    if (frame_start) begin
      next_r.bit_cnt = 5'd0;
      next_r.shift_in = 24'h000000;
      if (r.status_on_write_enable || r.rd_pending) begin
        next_r.shift_out = {`FSR_PAD_BITS, status};
        next_r.answering = 1'b1;
      end
      next_r.rd_pending = 1'b0;
    end else if (!sync_n_s) begin
      // first rising edge of a frame presents the top bit, no shift
      if (rise && r.bit_cnt != 5'd0) begin
        next_r.shift_out = {r.shift_out[22:0], 1'b0};
      end
      if (fall) begin
        next_r.shift_in = {r.shift_in[22:0], r.sdin_q[1]};
        if (r.bit_cnt != 5'h1f) begin
          next_r.bit_cnt = r.bit_cnt + 5'd1;
        end
      end
    end
    if (frame_end) begin
      next_r.answering = 1'b0;
      if (rd_status_cmd && !r.status_on_write_enable) begin
        next_r.rd_pending = 1'b1;
      end
    end
    // a failure in the clearing cycle still sets the flag
    next_r.pec_err = (r.pec_err & ~status_read_done) |
      packet_check_fail_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.sclk_q <= 2'h0;
      r.sync_q <= 2'h3;
      r.sync_prev <= 1'b1;
      r.user_toggle <= `FSR_RST_TOGGLE;
      r.pec_err <= `FSR_RST_PEC;
      r.status_on_write_enable <= `FSR_RST_SWE;
    end else begin
      r <= next_r;
    end
  end

  assign serial_data_out_o = r.shift_out[23];
  assign serial_data_out_oe_o = r.answering & ~sync_n_s;
  assign fault_status_o = status;
  assign fault_n_o = 1'b0;
  assign fault_oe_o = (|status.current_out) | r.pec_err |
    r.flags_q2.overtemp;

  property p_ro_word;
    @(posedge core_clk_i) disable iff (!rst_n)
    r.flags_q1 == r.flags_q2 && !toggle_write_i && !packet_check_fail_i &&
      !status_read_done |=> $stable(fault_status_o);
  endproperty
  a_ro_word: assert property (p_ro_word) else $error("status changed");

  property p_sow_load;
    @(posedge core_clk_i) disable iff (!rst_n)
    frame_start && r.status_on_write_enable |=>
      r.answering && r.shift_out[15:0] == $past(status);
  endproperty
  a_sow_load: assert property (p_sow_load) else $error("no status out");

  property p_readback;
    @(posedge core_clk_i) disable iff (!rst_n)
    frame_start && r.rd_pending |=> r.answering ##0 !r.rd_pending;
  endproperty
  a_readback: assert property (p_readback) else $error("no readback");

  property p_boost;
    @(posedge core_clk_i) disable iff (!rst_n)
    (fault_status_o.boost_compliance & ~fault_status_o.current_out) == 4'h0;
  endproperty
  a_boost: assert property (p_boost) else $error("boost w/o fault");

  property p_toggle;
    @(posedge core_clk_i) disable iff (!rst_n)
    toggle_write_i |=> fault_status_o.user_toggle == $past(toggle_value_i);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  property p_pec_set;
    @(posedge core_clk_i) disable iff (!rst_n)
    packet_check_fail_i |=> fault_status_o.packet_check && !fault_n_o &&
      fault_oe_o;
  endproperty
  a_pec_set: assert property (p_pec_set) else $error("pec not set");

  property p_ramp;
    @(posedge core_clk_i) disable iff (!rst_n)
    flags_i.ramp ##1 flags_i.ramp ##1 flags_i.ramp |->
      fault_status_o.ramp_active;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp lost");

  property p_temp;
    @(posedge core_clk_i) disable iff (!rst_n)
    flags_i.overtemp [*3] |-> fault_status_o.overtemp && fault_oe_o;
  endproperty
  a_temp: assert property (p_temp) else $error("overtemp lost");

  property p_iout;
    @(posedge core_clk_i) disable iff (!rst_n)
    flags_i.iout[0] [*3] |-> fault_status_o.current_out[0];
  endproperty
  a_iout: assert property (p_iout) else $error("iout lost");

  property p_unused;
    @(posedge core_clk_i) disable iff (!rst_n)
    fault_status_o.unused == 4'h0 &&
      (!$rose(r.answering) || r.shift_out[23:16] == 8'h00);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits");

  property p_clear;
    @(posedge core_clk_i) disable iff (!rst_n)
    status_read_done && !packet_check_fail_i |=>
      !fault_status_o.packet_check;
  endproperty
  a_clear: assert property (p_clear) else $error("pec not cleared");

  property p_sow_off;
    @(posedge core_clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> !r.status_on_write_enable;
  endproperty
  a_sow_off: assert property (p_sow_off) else $error("sow on");

  c_sow: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    frame_start && r.status_on_write_enable);
  c_rdb: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    frame_start && r.rd_pending);
  c_clr: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    r.pec_err ##1 !r.pec_err);
  c_flt: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    fault_oe_o && fault_status_o.overtemp);
endmodule // fsr_status
